// ---- verilog/pmi_top.sv ----
// I2C target front end and flag control of the power monitor
`timescale 1ns/1ps
module pmi_top (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic supply_low_lockout_i,
  input wire logic clk_en_i,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Address strap, already decoded to two bits
  input wire logic [1:0] addr_strap_i,
  // Converter interface
  output logic conv_start_o,
  output logic conv_sel_current_o,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  // Overcurrent inputs
  input wire logic threshold_voltage_input_trip_i,
  input wire logic mask_expired_i,
  input wire logic latch_clear_n_i,
  // Flag pin, open drain
  output logic flag_o,
  output logic flag_oe_n_o,
  // Configuration view
  output logic [7:0] command_o,
  output logic [7:0] flag_threshold_reg_o,
  output logic [7:0] control_o
);
  import pmi_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reset combines the pin reset and the supply lockout
  logic rst;
  assign rst = reset_i | supply_low_lockout_i;

  // Pin synchronisers; stage one read only by stage two
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic scl_s;
  logic sda_s;
  logic scl_p;
  logic sda_p;
  logic mx1_reg;
  logic mx2_reg;
  logic cl1_reg;
  logic cl2_reg;
  logic tr1_reg; // Comparator trip, first stage
  logic tr2_reg; // Comparator trip, safe to use
  always_ff @(posedge ref_clk_i or posedge rst) begin
    if (rst) begin
      s1_reg <= 2'h3;
      s2_reg <= 2'h3;
      s3_reg <= 2'h3;
      mx1_reg <= 1'b0;
      mx2_reg <= 1'b0;
      cl1_reg <= 1'b1;
      cl2_reg <= 1'b1;
      tr1_reg <= 1'b0;
      tr2_reg <= 1'b0;
    end else if (clk_en_i) begin
      s1_reg <= {scl_i, sda_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      mx1_reg <= mask_expired_i;
      mx2_reg <= mx1_reg;
      cl1_reg <= latch_clear_n_i;
      cl2_reg <= cl1_reg;
      tr1_reg <= threshold_voltage_input_trip_i;
      tr2_reg <= tr1_reg;
    end
  end
  assign scl_s = s2_reg[1];
  assign sda_s = s2_reg[0];
  assign scl_p = s3_reg[1];
  assign sda_p = s3_reg[0];

  // Bus events from synchronised samples
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;

  ////////////////////////////////////////////////////////////////////////
  // Own address: fixed prefix plus strap code, valid from reset
  logic [6:0] own_addr;
  assign own_addr = {PMI_ADDR_PREFIX, addr_strap_i};

  // Bus state
  pmi_state_e state_reg;
  pmi_state_e state_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic dir_reg;
  logic dir_next;
  logic first_reg;
  logic first_next;
  logic [1:0] ext_reg;
  logic [1:0] ext_next;
  logic [1:0] rd_idx_reg;
  logic [1:0] rd_idx_next;
  logic drive_reg;
  logic drive_next;
  logic out_bit_reg;
  logic out_bit_next;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [7:0] fen_reg;
  logic [7:0] fen_next;
  logic [7:0] th_reg;
  logic [7:0] th_next;
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic fen_wr;

  // Conversion state
  logic once_pend_reg;
  logic once_pend_next;
  logic start_reg;
  logic start_next;
  logic sel_i_reg;
  logic sel_i_next;
  logic [11:0] v_res_reg;
  logic [11:0] v_res_next;
  logic [11:0] i_res_reg;
  logic [11:0] i_res_next;

  // Read byte order: voltage high, current high, low nibbles packed
  function automatic logic [7:0] rd_byte(input logic [1:0] idx, input logic [11:0] v,
                                         input logic [11:0] i);
    logic [7:0] b;
    case (idx)
      2'h0: b = v[11:4];
      2'h1: b = i[11:4];
      default: b = {v[3:0], i[3:0]};
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus sequencing next values
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    dir_next = dir_reg;
    first_next = first_reg;
    ext_next = ext_reg;
    rd_idx_next = rd_idx_reg;
    drive_next = drive_reg;
    out_bit_next = out_bit_reg;
    cmd_next = cmd_reg;
    fen_next = fen_reg;
    th_next = th_reg;
    ctl_next = ctl_reg;
    once_pend_next = once_pend_reg;
    fen_wr = 1'b0;
    // Once commands self-clear at completion; placed first so a command
    // accepted in the same cycle overrides the clear
    if (conv_done_i && once_pend_reg) begin
      once_pend_next = 1'b0;
      cmd_next[PMI_CMD_V_ONCE] = 1'b0;
      cmd_next[PMI_CMD_I_ONCE] = 1'b0;
    end
    if (start_ev) begin
      // Start or repeated start restarts address shifting
      state_next = PMI_ADDR;
      bit_next = 4'h0;
      drive_next = 1'b0;
    end else if (stop_ev) begin
      state_next = PMI_IDLE;
      drive_next = 1'b0;
    end else begin
      case (state_reg)
        PMI_IDLE: begin
          drive_next = 1'b0;
        end
        PMI_ADDR, PMI_WDAT: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == PMI_BIT_ACK) begin
            bit_next = 4'h0;
            if (state_reg == PMI_ADDR) begin
              if (shift_reg[7:1] == own_addr &&
                  !(shift_reg[0] && once_pend_reg)) begin
                state_next = PMI_AACK;
                dir_next = shift_reg[0];
                drive_next = 1'b1;
                out_bit_next = 1'b0;
                first_next = 1'b1;
                rd_idx_next = 2'h0;
              end else begin
                state_next = PMI_IDLE;
              end
            end else begin
              state_next = PMI_WACK;
              drive_next = 1'b1;
              out_bit_next = 1'b0;
              if (first_reg) begin
                // Command byte; extended writes wait for their data
                first_next = 1'b0;
                if (shift_reg[PMI_CMD_EXT_BIT]) begin
                  ext_next = shift_reg[1:0];
                end else begin
                  ext_next = 2'h0;
                  cmd_next = shift_reg;
                  if (shift_reg[PMI_CMD_V_ONCE] || shift_reg[PMI_CMD_I_ONCE]) begin
                    once_pend_next = 1'b1;
                  end
                end
              end else begin
                case (ext_reg)
                  PMI_EXT_FLAG_EN: begin
                    fen_next = shift_reg;
                    fen_wr = 1'b1;
                  end
                  PMI_EXT_THRESH: th_next = shift_reg;
                  PMI_EXT_CONTROL: ctl_next = shift_reg;
                  default: ;
                endcase
              end
            end
          end
        end
        PMI_AACK, PMI_WACK: begin
          // Hold ack through the ninth high phase, release on its fall
          if (scl_fall) begin
            if (dir_reg) begin
              state_next = PMI_RDAT;
              shift_next = rd_byte(rd_idx_reg, v_res_reg, i_res_reg);
              out_bit_next = shift_next[7];
              drive_next = 1'b1;
              bit_next = 4'h0;
            end else begin
              state_next = PMI_WDAT;
              drive_next = 1'b0;
            end
          end
        end
        PMI_RDAT: begin
          if (scl_fall) begin
            if (bit_reg == PMI_BIT_LAST) begin
              state_next = PMI_RACK;
              drive_next = 1'b0;
            end else begin
              bit_next = bit_reg + 4'h1;
              shift_next = {shift_reg[6:0], 1'b0};
              out_bit_next = shift_reg[6];
            end
          end
        end
        PMI_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_next = PMI_IDLE;
            end else begin
              rd_idx_next = (rd_idx_reg == PMI_RD_BYTES - 2'h1) ? 2'h0 : rd_idx_reg + 2'h1;
              state_next = PMI_AACK;
              drive_next = 1'b0;
            end
          end
        end
        default: state_next = PMI_IDLE;
      endcase
    end
  end

  // Bus sequencing registers
  always_ff @(posedge ref_clk_i or posedge rst) begin
    if (rst) begin
      state_reg <= PMI_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      dir_reg <= 1'b0;
      first_reg <= 1'b0;
      ext_reg <= 2'h0;
      rd_idx_reg <= 2'h0;
      drive_reg <= 1'b0;
      out_bit_reg <= 1'b1;
      cmd_reg <= PMI_CMD_RESET;
      fen_reg <= PMI_FLAG_EN_RESET;
      th_reg <= PMI_THRESH_RESET;
      ctl_reg <= PMI_CONTROL_RESET;
      once_pend_reg <= 1'b0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      dir_reg <= dir_next;
      first_reg <= first_next;
      ext_reg <= ext_next;
      rd_idx_reg <= rd_idx_next;
      drive_reg <= drive_next;
      out_bit_reg <= out_bit_next;
      cmd_reg <= cmd_next;
      fen_reg <= fen_next;
      th_reg <= th_next;
      ctl_reg <= ctl_next;
      once_pend_reg <= once_pend_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter steering: alternate channels, start on request or continuous
  logic want_v;
  logic want_i;
  assign want_v = cmd_reg[PMI_CMD_V_CONT] | cmd_reg[PMI_CMD_V_ONCE];
  assign want_i = cmd_reg[PMI_CMD_I_CONT] | cmd_reg[PMI_CMD_I_ONCE];
  always_comb begin
    start_next = 1'b0;
    sel_i_next = sel_i_reg;
    v_res_next = v_res_reg;
    i_res_next = i_res_reg;
    if (conv_done_i) begin
      if (sel_i_reg) begin
        i_res_next = conv_data_i;
      end else begin
        v_res_next = conv_data_i;
      end
      sel_i_next = want_v && want_i ? ~sel_i_reg : want_i;
      start_next = (want_v || want_i) && !(once_pend_reg && !(want_v && want_i && !sel_i_reg));
    end else if (!start_reg && state_reg == PMI_WACK && first_reg == 1'b0 &&
                 bit_reg == 4'h0 && scl_fall && !ext_reg[0] && !ext_reg[1]) begin
      // New command just accepted: kick the converter
      start_next = want_v || want_i;
      sel_i_next = !want_v;
    end
  end

  // Converter registers
  always_ff @(posedge ref_clk_i or posedge rst) begin
    if (rst) begin
      start_reg <= 1'b0;
      sel_i_reg <= 1'b0;
      v_res_reg <= 12'h000;
      i_res_reg <= 12'h000;
    end else if (clk_en_i) begin
      start_reg <= start_next;
      sel_i_reg <= sel_i_next;
      v_res_reg <= v_res_next;
      i_res_reg <= i_res_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag latch; digital trip compares current result upper byte
  logic flag;
  pmi_flag_latch u_flag (
    .ref_clk_i(ref_clk_i),
    .reset_i(rst),
    .clk_en_i(clk_en_i),
    .comp_trip_i(tr2_reg),
    .digital_trip_i(i_res_reg[11:4] > th_reg),
    .use_digital_i(fen_reg[PMI_FLAG_SRC_DIGITAL]),
    .mask_expired_i(mx2_reg),
    .latch_clear_n_i(cl2_reg),
    .flag_en_write_i(fen_wr),
    .flag_o(flag)
  );

  // Outputs
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~(drive_reg & ~out_bit_reg);
  assign flag_o = 1'b0;
  assign flag_oe_n_o = flag;
  assign conv_start_o = start_reg;
  assign conv_sel_current_o = sel_i_reg;
  assign command_o = cmd_reg;
  assign flag_threshold_reg_o = th_reg;
  assign control_o = ctl_reg;
endmodule

// ---- verilog/pmi_pkg.sv ----
// Package of constants for the power monitor I2C target and flag latch
package pmi_pkg;
  // Address prefix and strap decode codes
  localparam logic [4:0] PMI_ADDR_PREFIX = 5'h0B;
  localparam logic [1:0] PMI_STRAP_GND = 2'h0;
  localparam logic [1:0] PMI_STRAP_RES = 2'h1;
  localparam logic [1:0] PMI_STRAP_FLOAT = 2'h2;
  localparam logic [1:0] PMI_STRAP_HIGH = 2'h3;
  // Command byte layout
  localparam int PMI_CMD_EXT_BIT = 7;
  localparam logic [1:0] PMI_EXT_FLAG_EN = 2'h1;
  localparam logic [1:0] PMI_EXT_THRESH = 2'h2;
  localparam logic [1:0] PMI_EXT_CONTROL = 2'h3;
  localparam int PMI_CMD_V_CONT = 0;
  localparam int PMI_CMD_V_ONCE = 1;
  localparam int PMI_CMD_I_CONT = 2;
  localparam int PMI_CMD_I_ONCE = 3;
  // Flag source enable bit: 1 selects the digital threshold compare
  localparam int PMI_FLAG_SRC_DIGITAL = 0;
  // Reset values
  localparam logic [7:0] PMI_CMD_RESET = 8'h00;
  localparam logic [7:0] PMI_FLAG_EN_RESET = 8'h00;
  localparam logic [7:0] PMI_THRESH_RESET = 8'hFF;
  localparam logic [7:0] PMI_CONTROL_RESET = 8'h00;
  // Bit counter values
  localparam logic [3:0] PMI_BIT_ACK = 4'h8;
  localparam logic [3:0] PMI_BIT_LAST = 4'h7;
  // Read frame length in bytes
  localparam logic [1:0] PMI_RD_BYTES = 2'h3;
  // Bus states
  typedef enum logic [2:0] {
    PMI_IDLE = 3'h0,
    PMI_ADDR = 3'h1,
    PMI_AACK = 3'h3,
    PMI_WDAT = 3'h2,
    PMI_WACK = 3'h6,
    PMI_RDAT = 3'h7,
    PMI_RACK = 3'h5
  } pmi_state_e;
endpackage

// ---- verilog/pmi_flag_latch.sv ----
// Overcurrent flag latch with mask-timer qualification and clear pin
`timescale 1ns/1ps
module pmi_flag_latch (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Trip sources
  input wire logic comp_trip_i,
  input wire logic digital_trip_i,
  input wire logic use_digital_i,
  input wire logic mask_expired_i,
  // Clears
  input wire logic latch_clear_n_i,
  input wire logic flag_en_write_i,
  // Flag
  output logic flag_o
);
  import pmi_pkg::*;

  logic flag_reg;
  logic flag_next;
  logic trip;

  ////////////////////////////////////////////////////////////////////////
  // Next flag value; the clear pin dominates so a held-low pin keeps it off
  // A qualified trip beats a coincident enable write, so no event is lost
  always_comb begin
    trip = use_digital_i ? digital_trip_i : comp_trip_i;
    flag_next = flag_reg;
    if (!latch_clear_n_i) begin
      flag_next = 1'b0;
    end else if (trip && mask_expired_i) begin
      flag_next = 1'b1;
    end else if (flag_en_write_i) begin
      flag_next = 1'b0;
    end
  end

  // Flag register
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flag_reg <= 1'b0;
    end else if (clk_en_i) begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule

// ---- dv/pmi_top_checker.sv ----
// Concurrent checks on the power monitor target ports
`timescale 1ns/1ps
module pmi_top_checker (
  // Clock, reset, lockout
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic supply_low_lockout_i,
  input wire logic clk_en_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  // Converter and flag
  input wire logic conv_start_o,
  input wire logic mask_expired_i,
  input wire logic latch_clear_n_i,
  input wire logic flag_o,
  input wire logic flag_oe_n_o
);
  // Lockout acts as a second reset, so both silence every other check; only reset silences chk_lockout_reset
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i || supply_low_lockout_i);
  //////////////////////////////////////////////////////////////////////////////
  // Start condition on the pins
  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  // Clear pin low long enough to pass the synchroniser
  sequence s_clear_held;
    (!latch_clear_n_i && clk_en_i)[*4];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  chk_sda_open_drain: assert property (!sda_o)
    else $error("SDA data driven high");
  chk_flag_open_drain: assert property (!flag_o)
    else $error("Flag data driven high");
  chk_sda_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("SDA drive changed while SCL high");
  chk_addr_quiet: assert property (s_start |-> sda_oe_n_o[*8])
    else $error("SDA pulled during address phase");
  chk_clear_holds: assert property (s_clear_held |-> !flag_oe_n_o)
    else $error("Flag asserted while clear held low");
  chk_mask_gate: assert property ($rose(flag_oe_n_o) |->
    $past(mask_expired_i, 2) || $past(mask_expired_i, 3) || $past(mask_expired_i, 4))
    else $error("Flag set without mask expiry");
  chk_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("Conversion start longer than one cycle");
  // Lockout must hold outputs at their reset levels
  chk_lockout_reset: assert property (disable iff (reset_i)
    supply_low_lockout_i |-> sda_oe_n_o && !flag_oe_n_o && !conv_start_o)
    else $error("Outputs active during lockout");
endmodule

bind pmi_top pmi_top_checker u_chk (
  .ref_clk_i(ref_clk_i),
  .reset_i(reset_i),
  .supply_low_lockout_i(supply_low_lockout_i),
  .clk_en_i(clk_en_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o),
  .conv_start_o(conv_start_o),
  .mask_expired_i(mask_expired_i),
  .latch_clear_n_i(latch_clear_n_i),
  .flag_o(flag_o),
  .flag_oe_n_o(flag_oe_n_o)
);

// ---- dv/pmi_i2c_master.sv ----
// Bus master model driving SCL and its side of the open-drain SDA
`timescale 1ns/1ps
module pmi_i2c_master (
  // Bus lines, high means released to the pull-up
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // SCL stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One bit: set in SCL low, sampled mid SCL high, 200 ns period
  task automatic bit_io(input logic b, output logic r);
    #50 sda_o = b;
    #75 scl_o = 1'b1;
    #37 r = sda_i;
    #38 scl_o = 1'b0;
  endtask
  // SDA falls with SCL high
  task automatic start();
    sda_o = 1'b0;
    #100 scl_o = 1'b0;
  endtask
  // SDA rises with SCL high
  task automatic stop();
    #50 sda_o = 1'b0;
    #75 scl_o = 1'b1;
    #75 sda_o = 1'b1;
    #100;
  endtask
  // Eight bits MSB first, ninth pulse for the target's ack
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Last byte is refused so the target lets go before stop
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
endmodule

// ---- dv/pmi_top_tb.sv ----
// Self-checking bench for the power monitor target and flag latch
`timescale 1ns/1ps
module pmi_top_tb;
  import pmi_pkg::*;
  // Stimulus state
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic lockout = 1'b0;
  logic en = 1'b1;
  logic [1:0] strap = 2'h0;
  logic trip = 1'b0;
  logic mask = 1'b0;
  logic clear_n = 1'b1;
  logic conv_done = 1'b0;
  logic pend = 1'b0;
  logic hold = 1'b0;
  logic [11:0] conv_data = 12'h000;
  // Design outputs
  logic scl, sda_m, sda_o, sda_oe_n, conv_start, conv_sel, flag, flag_oe_n;
  logic [7:0] cmd, thr, ctl;
  // Open-drain wire with pull-up
  wire logic sda_w = sda_m & sda_oe_n;
  wire logic [7:0] own_w = {PMI_ADDR_PREFIX, strap, 1'b0};
  int error_cnt = 0;
  int n_compared = 0;
  //////////////////////////////////////////////////////////////////////////////
  pmi_top u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .supply_low_lockout_i(lockout),
    .clk_en_i(en), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .addr_strap_i(strap), .conv_start_o(conv_start), .conv_sel_current_o(conv_sel),
    .conv_done_i(conv_done), .conv_data_i(conv_data), .threshold_voltage_input_trip_i(trip),
    .mask_expired_i(mask), .latch_clear_n_i(clear_n), .flag_o(flag), .flag_oe_n_o(flag_oe_n),
    .command_o(cmd), .flag_threshold_reg_o(thr), .control_o(ctl));
  pmi_i2c_master u_master (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_w));
  always #12.5 ref_clk_i = ~ref_clk_i;
  // Converter: finishes a cycle after start unless held back
  always @(negedge ref_clk_i) begin
    conv_done = pend && !hold;
    conv_data = conv_sel ? 12'hC35 : 12'h5A7;
    pend = conv_start || (pend && !conv_done);
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Write frame: address then n bytes, all acks and-ed
  task automatic wr(input logic [7:0] ab, input logic [15:0] d, input int n, output logic ok);
    logic a;
    u_master.start();
    u_master.send(ab, ok);
    for (int i = 0; i < n; i++) begin
      u_master.send(d[15-8*i -: 8], a);
      ok = ok & a;
    end
    u_master.stop();
  endtask
  // Bounded wait for the flag level
  task automatic wait_flag(input logic exp);
    int n = 0;
    while (flag_oe_n !== exp && n < 40) begin
      cyc(1);
      n++;
    end
    check("flag settle", flag_oe_n, exp);
    if (flag_oe_n !== exp) stop_test();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    check("command", cmd, PMI_CMD_RESET);
    check("threshold", thr, PMI_THRESH_RESET);
    check("control", ctl, PMI_CONTROL_RESET);
    check("flag", flag_oe_n, 1'b0);
  endtask
  task automatic t_address();
    logic ok;
    for (int k = 0; k < 4; k++) begin
      strap = k[1:0];
      cyc(2);
      wr({PMI_ADDR_PREFIX, k[1:0], 1'b0}, 16'h0, 0, ok);
      check("own address ack", ok, 1'b1);
      wr({PMI_ADDR_PREFIX, ~k[1:0], 1'b0}, 16'h0, 0, ok);
      check("strap mismatch ack", ok, 1'b0);
      wr({PMI_ADDR_PREFIX ^ 5'h01, k[1:0], 1'b0}, 16'h0, 0, ok);
      check("prefix mismatch ack", ok, 1'b0);
    end
  endtask
  task automatic t_commands();
    logic ok;
    wr(own_w, 16'h0500, 1, ok);
    check("command byte", cmd, 8'h05);
    wr(own_w, 16'h8240, 2, ok);
    check("threshold write", thr, 8'h40);
    wr(own_w, 16'h8301, 2, ok);
    check("control write", ctl, 8'h01);
    check("write acks", ok, 1'b1);
  endtask
  // Read refused while a single shot is pending, then continuous three-byte read
  task automatic t_readback();
    logic ok;
    logic [7:0] b;
    hold = 1'b1;
    wr(own_w, 16'h0200, 1, ok);
    wr(own_w | 8'h01, 16'h0, 0, ok);
    check("read while pending", ok, 1'b0);
    hold = 1'b0;
    cyc(4);
    u_master.start();
    u_master.send(own_w | 8'h01, ok);
    check("read ack", ok, 1'b1);
    u_master.recv(1'b1, b);
    u_master.stop();
    check("single voltage high", b, 8'h5A);
    wr(own_w, 16'h0500, 1, ok);
    cyc(20);
    u_master.start();
    u_master.send(own_w | 8'h01, ok);
    u_master.recv(1'b0, b);
    check("voltage high", b, 8'h5A);
    u_master.recv(1'b0, b);
    check("current high", b, 8'hC3);
    u_master.recv(1'b1, b);
    u_master.stop();
    check("packed low nibbles", b, 8'h75);
  endtask
  task automatic t_flag();
    logic ok;
    trip = 1'b1;
    cyc(8);
    check("flag before expiry", flag_oe_n, 1'b0);
    mask = 1'b1;
    wait_flag(1'b1);
    trip = 1'b0;
    mask = 1'b0;
    cyc(8);
    check("flag latched", flag_oe_n, 1'b1);
    clear_n = 1'b0;
    trip = 1'b1;
    mask = 1'b1;
    cyc(8);
    check("flag held off", flag_oe_n, 1'b0);
    trip = 1'b0;
    mask = 1'b0;
    cyc(2);
    clear_n = 1'b1;
    cyc(8);
    check("flag after clear", flag_oe_n, 1'b0);
    trip = 1'b1;
    mask = 1'b1;
    wait_flag(1'b1);
    trip = 1'b0;
    mask = 1'b0;
    wr(own_w, 16'h8100, 2, ok);
    check("flag after enable write", flag_oe_n, 1'b0);
    wr(own_w, 16'h8240, 2, ok);
    wr(own_w, 16'h8101, 2, ok);
    wr(own_w, 16'h0400, 1, ok);
    cyc(20);
    mask = 1'b1;
    wait_flag(1'b1);
  endtask
  // Enable low freezes the latched flag even with the clear pin low
  task automatic t_clk_en();
    logic ok;
    wr(own_w, 16'h0000, 1, ok);
    check("command idle", cmd, 8'h00);
    cyc(8);
    en = 1'b0;
    clear_n = 1'b0;
    cyc(8);
    check("flag frozen", flag_oe_n, 1'b1);
    en = 1'b1;
    cyc(8);
    check("flag cleared after enable", flag_oe_n, 1'b0);
    clear_n = 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #2ms;
    error_cnt++;
    stop_test();
  end
  initial begin
    cyc(2);
    reset_i = 1'b0;
    cyc(3);
    t_reset_vals();
    t_address();
    t_commands();
    lockout = 1'b1;
    cyc(3);
    lockout = 1'b0;
    cyc(3);
    t_reset_vals();
    t_readback();
    t_flag();
    t_clk_en();
    stop_test();
  end
endmodule
